// >>> core/ett_timer_core.sv
// counter core of an eight-bit timer counter with two compare channels
`timescale 1ns/1ns
`include "ett_cfg.svh"

// What this block does
// - count and compares are 8-bit CPU registers
// - tick from prescaler or external count pin
// - selector picks source and active edge
// - selector zero: no ticks, counter stopped
// - count readable and writable at any time
// - CPU count write beats clear or count
// - each tick clears, increments or decrements
// - bidirectional counter with internal direction bit
// - three-bit mode split across control A/B
// - clock source selector lives in control B
// - flag bottom at 0x00, max at 0xFF
// - top is 0xFF or compare A
// - compares checked against count continuously
// - compare match sets that channel's flag
// - flags visible together, each individually maskable
// - overflow flag set per waveform mode
// - three interrupt sources: overflow, A, B
// - match sets flag on the next tick
// - write-one or interrupt service clears flag
// - mode 0: up, wrap, overflow at zero
// - mode 2: clear on compare A match

module ett_timer_core (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ext_count_pin,
  input wire ett_pkg::ett_wr_s count_wr,
  input wire ett_pkg::ett_wr_s compare_a_wr,
  input wire ett_pkg::ett_wr_s compare_b_wr,
  input wire ett_pkg::ett_wr_s ctrl_a_wr,
  input wire ett_pkg::ett_wr_s ctrl_b_wr,
  input wire ett_pkg::ett_wr_s irq_mask_wr,
  input wire ett_pkg::ett_wr_s irq_flag_clr,
  input wire logic [2:0] irq_service_ack,
  output logic [7:0] count_value,
  output logic [7:0] compare_a_value,
  output logic [7:0] compare_b_value,
  output logic [7:0] control_reg_a,
  output logic [7:0] control_reg_b,
  output logic [7:0] timer_irq_flag_reg,
  output logic [7:0] timer_irq_mask_reg,
  output logic [2:0] irq_req,
  output logic at_bottom,
  output logic at_max,
  output logic match_a,
  output logic match_b,
  output logic count_dir_up
);

  // =============================================================
  // state
  logic [7:0] count_q; // counter
  logic [7:0] count_d;
  logic dir_up_q; // direction, one counts up
  logic dir_up_d;
  logic [7:0] ctrl_a_q; // control A, defined bits only
  logic [7:0] ctrl_b_q; // control B, defined bits only
  logic [7:0] buf_a_q; // CPU side of compare A
  logic [7:0] buf_b_q; // CPU side of compare B
  logic [7:0] act_a_q; // value compared against the count
  logic [7:0] act_b_q;
  logic [7:0] act_a_d;
  logic [7:0] act_b_d;
  logic block_q; // count was written, next tick sees no match
  logic [2:0] flag_q; // overflow, match A, match B
  logic [2:0] flag_d;
  logic [2:0] mask_q; // interrupt masks
  logic [2:0] irq_q; // registered requests
  logic bottom_q; // registered bottom indication
  logic max_q; // registered max indication
  logic match_a_q; // registered compare A equality
  logic match_b_q; // registered compare B equality

  // =============================================================
  // decode
  logic timer_tick; // one-cycle tick from the clock selector
  logic [2:0] waveform_mode_sel; // full three-bit mode
  logic [2:0] clock_source_sel; // clock selector field
  ett_pkg::ett_seq_e seq; // sequence family of the mode
  logic [7:0] top_val; // top of the sequence
  logic pwm; // buffered compare modes
  logic ovf_set; // overflow event this cycle
  logic upd; // load buffered compares this cycle
  logic set_a; // compare A event this cycle
  logic set_b; // compare B event this cycle
  logic [2:0] clr; // flag clears this cycle

  // mode bits 1:0 in control A, bit 2 in control B
  assign waveform_mode_sel = {ctrl_b_q[`ETT_WGM_HI_BIT],
    ctrl_a_q[`ETT_WGM_LO_MSB:`ETT_WGM_LO_LSB]};
  assign clock_source_sel =
    ctrl_b_q[`ETT_CS_MSB:`ETT_CS_LSB];

  // =============================================================
  // clock selection
  ett_tick_gen u_tick (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clock_source_sel(clock_source_sel),
    .ext_count_pin(ext_count_pin),
    .timer_tick(timer_tick)
  );

  // =============================================================
  // mode decode: family and top value
  // reserved modes fall back to the plain up count
  always_comb
  begin
    case (waveform_mode_sel)
      `ETT_WGM_NORMAL:
      begin
        seq = ett_pkg::ETT_SEQ_NORMAL;
        top_val = `ETT_MAX;
      end
      `ETT_WGM_CTC:
      begin
        seq = ett_pkg::ETT_SEQ_CTC;
        top_val = act_a_q;
      end
      `ETT_WGM_PC_MAX:
      begin
        seq = ett_pkg::ETT_SEQ_PHASE;
        top_val = `ETT_MAX;
      end
      `ETT_WGM_PC_CMP:
      begin
        seq = ett_pkg::ETT_SEQ_PHASE;
        top_val = act_a_q;
      end
      `ETT_WGM_FAST_MAX:
      begin
        seq = ett_pkg::ETT_SEQ_FAST;
        top_val = `ETT_MAX;
      end
      `ETT_WGM_FAST_CMP:
      begin
        seq = ett_pkg::ETT_SEQ_FAST;
        top_val = act_a_q;
      end
      default:
      begin
        seq = ett_pkg::ETT_SEQ_NORMAL;
        top_val = `ETT_MAX;
      end
    endcase
  end

  assign pwm = (seq == ett_pkg::ETT_SEQ_FAST) ||
    (seq == ett_pkg::ETT_SEQ_PHASE);

  // =============================================================
  // next count, direction and overflow event
  always_comb
  begin
    count_d = count_q;
    dir_up_d = 1'b1;
    ovf_set = 1'b0;
    upd = 1'b0;
    if (timer_tick)
    begin
      case (seq)
        ett_pkg::ETT_SEQ_NORMAL:
        begin
          // plain up count, wraps through zero
          count_d = count_q + `ETT_ONE;
          ovf_set = (count_q == `ETT_MAX);
        end
        ett_pkg::ETT_SEQ_CTC:
        begin
          if (count_q == top_val)
            count_d = `ETT_BOTTOM;
          else
            count_d = count_q + `ETT_ONE;
          ovf_set = (count_q == `ETT_MAX);
        end
        ett_pkg::ETT_SEQ_FAST:
        begin
          // overflow and buffer load where the count restarts
          if (count_q == top_val)
          begin
            count_d = `ETT_BOTTOM;
            ovf_set = 1'b1;
            upd = 1'b1;
          end
          else
            count_d = count_q + `ETT_ONE;
        end
        ett_pkg::ETT_SEQ_PHASE:
        begin
          // up to top, down to bottom; overflow at bottom
          if (dir_up_q)
          begin
            if (count_q == top_val)
            begin
              dir_up_d = 1'b0;
              count_d = count_q - `ETT_ONE;
              upd = 1'b1;
            end
            else
              count_d = count_q + `ETT_ONE;
          end
          else
          begin
            if (count_q == `ETT_BOTTOM)
            begin
              count_d = count_q + `ETT_ONE;
              ovf_set = 1'b1;
            end
            else
            begin
              dir_up_d = 1'b0;
              count_d = count_q - `ETT_ONE;
            end
          end
        end
        default:
          count_d = count_q;
      endcase
    end
    else if (seq == ett_pkg::ETT_SEQ_PHASE)
      dir_up_d = dir_up_q; // direction holds between ticks
    // a CPU write wins over any clear or count in the same cycle
    if (count_wr.en)
      count_d = count_wr.data;
  end

  // =============================================================
  // counter and direction registers
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_q <= `ETT_RST_8;
      dir_up_q <= 1'b1;
    end
    else
    begin
      count_q <= count_d;
      dir_up_q <= dir_up_d;
    end
  end

  // =============================================================
  // control and mask registers, undefined bits read zero
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_a_q <= `ETT_RST_8;
      ctrl_b_q <= `ETT_RST_8;
      mask_q <= 3'h0;
    end
    else
    begin
      if (ctrl_a_wr.en)
        ctrl_a_q <= ctrl_a_wr.data & `ETT_CTRL_A_MASK;
      if (ctrl_b_wr.en)
        ctrl_b_q <= ctrl_b_wr.data & `ETT_CTRL_B_MASK;
      if (irq_mask_wr.en)
        mask_q <= irq_mask_wr.data[2:0];
    end
  end

  // =============================================================
  // compare registers
  // pwm modes load the compared value only at the top, so a write
  // mid-period cannot give a short pulse; other modes act at once
  always_comb
  begin
    act_a_d = act_a_q;
    act_b_d = act_b_q;
    if (!pwm)
    begin
      act_a_d = compare_a_wr.en ? compare_a_wr.data : buf_a_q;
      act_b_d = compare_b_wr.en ? compare_b_wr.data : buf_b_q;
    end
    else if (upd)
    begin
      act_a_d = buf_a_q;
      act_b_d = buf_b_q;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      buf_a_q <= `ETT_RST_8;
      buf_b_q <= `ETT_RST_8;
      act_a_q <= `ETT_RST_8;
      act_b_q <= `ETT_RST_8;
    end
    else
    begin
      if (compare_a_wr.en)
        buf_a_q <= compare_a_wr.data;
      if (compare_b_wr.en)
        buf_b_q <= compare_b_wr.data;
      act_a_q <= act_a_d;
      act_b_q <= act_b_d;
    end
  end

  // =============================================================
  // match blocking after a count write
  // lets software load count equal to a compare without a flag
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      block_q <= 1'b0;
    else if (count_wr.en)
      block_q <= 1'b1;
    else if (timer_tick)
      block_q <= 1'b0;
  end

  // =============================================================
  // flags: equality seen at a tick sets the flag at that tick edge
  assign set_a = timer_tick && !block_q && !count_wr.en &&
    (count_q == act_a_q);
  assign set_b = timer_tick && !block_q && !count_wr.en &&
    (count_q == act_b_q);
  assign clr = (irq_flag_clr.en ? irq_flag_clr.data[2:0] : 3'h0) |
    irq_service_ack;

  // set beats clear so an event in the clearing cycle survives
  always_comb
  begin
    flag_d[`ETT_BIT_OVF] = ovf_set ||
      (flag_q[`ETT_BIT_OVF] && !clr[`ETT_BIT_OVF]);
    flag_d[`ETT_BIT_MATCH_A] = set_a ||
      (flag_q[`ETT_BIT_MATCH_A] && !clr[`ETT_BIT_MATCH_A]);
    flag_d[`ETT_BIT_MATCH_B] = set_b ||
      (flag_q[`ETT_BIT_MATCH_B] && !clr[`ETT_BIT_MATCH_B]);
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flag_q <= 3'h0;
      irq_q <= 3'h0;
    end
    else
    begin
      flag_q <= flag_d;
      irq_q <= flag_q & mask_q;
    end
  end

  // =============================================================
  // registered indications of the current count
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bottom_q <= 1'b0;
      max_q <= 1'b0;
      match_a_q <= 1'b0;
      match_b_q <= 1'b0;
    end
    else
    begin
      bottom_q <= (count_q == `ETT_BOTTOM);
      max_q <= (count_q == `ETT_MAX);
      match_a_q <= (count_q == act_a_q);
      match_b_q <= (count_q == act_b_q);
    end
  end

  // =============================================================
  // outputs, each straight from a flop
  assign count_value = count_q;
  assign compare_a_value = buf_a_q;
  assign compare_b_value = buf_b_q;
  assign control_reg_a = ctrl_a_q;
  assign control_reg_b = ctrl_b_q;
  assign timer_irq_flag_reg = {5'h00, flag_q};
  assign timer_irq_mask_reg = {5'h00, mask_q};
  assign irq_req = irq_q;
  assign at_bottom = bottom_q;
  assign at_max = max_q;
  assign match_a = match_a_q;
  assign match_b = match_b_q;
  assign count_dir_up = dir_up_q;

endmodule // ett_timer_core

// >>> core/ett_cfg.svh
// constants of the eight-bit timer counter core: widths, fields, codes
`ifndef ETT_CFG_SVH
`define ETT_CFG_SVH

// =============================================================
// count range
`define ETT_BOTTOM 8'h00
`define ETT_MAX 8'hff
`define ETT_ONE 8'h01
`define ETT_RST_8 8'h00

// =============================================================
// control register fields
`define ETT_CTRL_A_MASK 8'h03
`define ETT_CTRL_B_MASK 8'h0f
`define ETT_WGM_LO_MSB 1
`define ETT_WGM_LO_LSB 0
`define ETT_WGM_HI_BIT 3
`define ETT_CS_MSB 2
`define ETT_CS_LSB 0

// =============================================================
// flag and mask register fields
`define ETT_IRQ_MASK 8'h07
`define ETT_BIT_OVF 0
`define ETT_BIT_MATCH_A 1
`define ETT_BIT_MATCH_B 2

// =============================================================
// clock source codes
`define ETT_CS_OFF 3'h0
`define ETT_CS_DIV1 3'h1
`define ETT_CS_DIV8 3'h2
`define ETT_CS_DIV64 3'h3
`define ETT_CS_DIV256 3'h4
`define ETT_CS_DIV1024 3'h5
`define ETT_CS_EXT_FALL 3'h6
`define ETT_CS_EXT_RISE 3'h7

// =============================================================
// prescaler terminal masks, a tick when all masked bits are one
`define ETT_PS_ONE 10'h001
`define ETT_PS_RST 10'h000
`define ETT_PS_M8 10'h007
`define ETT_PS_M64 10'h03f
`define ETT_PS_M256 10'h0ff
`define ETT_PS_M1024 10'h3ff

// =============================================================
// waveform mode codes
`define ETT_WGM_NORMAL 3'h0
`define ETT_WGM_PC_MAX 3'h1
`define ETT_WGM_CTC 3'h2
`define ETT_WGM_FAST_MAX 3'h3
`define ETT_WGM_PC_CMP 3'h5
`define ETT_WGM_FAST_CMP 3'h7

`endif

// >>> core/ett_pkg.sv
// types shared by the eight-bit timer counter core
package ett_pkg;

  // =============================================================
  // one byte write strobe with its data
  typedef struct packed {
    logic en; // one-cycle write pulse
    logic [7:0] data; // value written
  } ett_wr_s;

  // =============================================================
  // counting sequence families, one-hot
  typedef enum logic [3:0] {
    ETT_SEQ_NORMAL = 4'b0001,
    ETT_SEQ_CTC = 4'b0010,
    ETT_SEQ_FAST = 4'b0100,
    ETT_SEQ_PHASE = 4'b1000
  } ett_seq_e;

endpackage

// >>> core/ett_tick_gen.sv
// clock selection: prescaler, external pin synchroniser and edge choice
`timescale 1ns/1ns
`include "ett_cfg.svh"

module ett_tick_gen (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [2:0] clock_source_sel,
  input wire logic ext_count_pin,
  output logic timer_tick
);

  logic [9:0] ps_q; // free running prescaler
  logic sync1_q; // first synchroniser stage, read only by sync2_q
  logic sync2_q; // second synchroniser stage
  logic hist_q; // previous synchronised level, for edges
  logic tick_d; // selected tick, combinational
  logic tick_q; // registered tick pulse

  // =============================================================
  // prescaler
  // free running so a source change does not restart the division
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      ps_q <= `ETT_PS_RST;
    else
      ps_q <= ps_q + `ETT_PS_ONE;
  end

  // =============================================================
  // external pin: two flops, then one more to find edges
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      hist_q <= 1'b0;
    end
    else
    begin
      sync1_q <= ext_count_pin;
      sync2_q <= sync1_q;
      hist_q <= sync2_q;
    end
  end

  // =============================================================
  // source and edge choice; code zero gives no tick at all
  always_comb
  begin
    case (clock_source_sel)
      `ETT_CS_OFF: tick_d = 1'b0;
      `ETT_CS_DIV1: tick_d = 1'b1;
      `ETT_CS_DIV8: tick_d = &(ps_q | ~`ETT_PS_M8);
      `ETT_CS_DIV64: tick_d = &(ps_q | ~`ETT_PS_M64);
      `ETT_CS_DIV256: tick_d = &(ps_q | ~`ETT_PS_M256);
      `ETT_CS_DIV1024: tick_d = &(ps_q | ~`ETT_PS_M1024);
      `ETT_CS_EXT_FALL: tick_d = hist_q & ~sync2_q;
      `ETT_CS_EXT_RISE: tick_d = sync2_q & ~hist_q;
      default: tick_d = 1'b0;
    endcase
  end

  // =============================================================
  // registered tick, one cycle wide
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      tick_q <= 1'b0;
    else
      tick_q <= tick_d;
  end

  assign timer_tick = tick_q;

endmodule // ett_tick_gen

// >>> tb/ett_timer_core_props.sv
// port-level assertions for the eight-bit timer counter core
`timescale 1ns/1ns
module ett_timer_core_props (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire ett_pkg::ett_wr_s count_wr,
  input wire ett_pkg::ett_wr_s ctrl_b_wr,
  input wire ett_pkg::ett_wr_s irq_mask_wr,
  input wire ett_pkg::ett_wr_s irq_flag_clr,
  input wire logic [2:0] irq_service_ack,
  input wire logic [7:0] count_value,
  input wire logic [7:0] compare_a_value,
  input wire logic [7:0] control_reg_a,
  input wire logic [7:0] control_reg_b,
  input wire logic [7:0] timer_irq_flag_reg,
  input wire logic [7:0] timer_irq_mask_reg,
  input wire logic [2:0] irq_req,
  input wire logic at_max,
  input wire logic match_a
);
  // ==========================================================
  // helper logic
  logic [1:0] idle_q; // cycles with clock select at zero, saturating
  // a tick already in the pipe may land just after select clears
  wire stopped = (idle_q == 2'h3) && (control_reg_b[2:0] == 3'h0);
  wire normal_mode = (control_reg_a[1:0] == 2'h0) && !control_reg_b[3];
  // count idle cycles of the selector
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      idle_q <= 2'h0;
    else if (control_reg_b[2:0] != 3'h0)
      idle_q <= 2'h0;
    else if (idle_q != 2'h3)
      idle_q <= idle_q + 2'h1;
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  property p_count_write;
    count_wr.en |=> count_value == $past(count_wr.data);
  endproperty
  a_count_write: assert property (p_count_write)
    else $error("count write lost");
  property p_ctrl_b;
    ctrl_b_wr.en |=> control_reg_b == {4'h0, $past(ctrl_b_wr.data[3:0])};
  endproperty
  a_ctrl_b: assert property (p_ctrl_b)
    else $error("control b write wrong");
  property p_mask;
    irq_mask_wr.en |=>
      timer_irq_mask_reg == {5'h0, $past(irq_mask_wr.data[2:0])};
  endproperty
  a_mask: assert property (p_mask)
    else $error("mask write wrong");
  property p_stopped;
    stopped && !count_wr.en |=> count_value == $past(count_value);
  endproperty
  a_stopped: assert property (p_stopped)
    else $error("count moved while stopped");
  property p_w1c;
    stopped && irq_flag_clr.en && irq_service_ack == 3'h0 |=>
      timer_irq_flag_reg[2:0] ==
      ($past(timer_irq_flag_reg[2:0]) & ~$past(irq_flag_clr.data[2:0]));
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("write-one clear wrong");
  property p_irq_req;
    $past(rst_n) |->
      irq_req == $past(timer_irq_flag_reg[2:0] & timer_irq_mask_reg[2:0]);
  endproperty
  a_irq_req: assert property (p_irq_req)
    else $error("request not flag and mask");
  property p_at_max;
    $past(rst_n) |-> at_max == ($past(count_value) == 8'hff);
  endproperty
  a_at_max: assert property (p_at_max)
    else $error("max indication wrong");
  property p_match_a;
    $past(rst_n) && !$past(control_reg_a[0]) |->
      match_a == ($past(count_value) == $past(compare_a_value));
  endproperty
  a_match_a: assert property (p_match_a)
    else $error("match a indication wrong");
  property p_ovf_wrap;
    $rose(timer_irq_flag_reg[0]) && normal_mode && $past(normal_mode)
      && !$past(count_wr.en) |-> count_value == 8'h00;
  endproperty
  a_ovf_wrap: assert property (p_ovf_wrap)
    else $error("overflow not at wrap");
endmodule // ett_timer_core_props

// >>> tb/tb_ett_timer_core.sv
// self-checking bench for the eight-bit timer counter core
`timescale 1ns/1ns
module tb_ett_timer_core;
  // ==========================================================
  // signals
  localparam int R_CNT = 0; // register select codes for wr
  localparam int R_CMPA = 1;
  localparam int R_CMPB = 2;
  localparam int R_CTA = 3;
  localparam int R_CTB = 4;
  localparam int R_MSK = 5;
  logic core_clk; // system clock
  logic rst_n; // active low reset
  logic ext_count_pin; // external count input
  logic [2:0] irq_service_ack; // service clear pulses
  ett_pkg::ett_wr_s count_wr, compare_a_wr, compare_b_wr; // strobes
  ett_pkg::ett_wr_s ctrl_a_wr, ctrl_b_wr, irq_mask_wr, irq_flag_clr;
  logic [7:0] count_value, compare_a_value, compare_b_value;
  logic [7:0] control_reg_a, control_reg_b;
  logic [7:0] timer_irq_flag_reg, timer_irq_mask_reg;
  logic [2:0] irq_req;
  logic at_bottom, at_max, match_a, match_b, count_dir_up;
  int err_total; // mismatches
  int samples_checked; // comparisons
  ett_timer_core uut (
    .core_clk(core_clk), .rst_n(rst_n), .ext_count_pin(ext_count_pin),
    .count_wr(count_wr), .compare_a_wr(compare_a_wr),
    .compare_b_wr(compare_b_wr), .ctrl_a_wr(ctrl_a_wr),
    .ctrl_b_wr(ctrl_b_wr), .irq_mask_wr(irq_mask_wr),
    .irq_flag_clr(irq_flag_clr), .irq_service_ack(irq_service_ack),
    .count_value(count_value), .compare_a_value(compare_a_value),
    .compare_b_value(compare_b_value), .control_reg_a(control_reg_a),
    .control_reg_b(control_reg_b), .timer_irq_flag_reg(timer_irq_flag_reg),
    .timer_irq_mask_reg(timer_irq_mask_reg), .irq_req(irq_req),
    .at_bottom(at_bottom), .at_max(at_max), .match_a(match_a),
    .match_b(match_b), .count_dir_up(count_dir_up)
  );
  // ==========================================================
  // shared tasks
  task automatic cyc(input int n); // wait edges, then settle
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check1(input logic got, input logic exp);
    check8({7'h0, got}, {7'h0, exp});
  endtask
  // one-cycle strobe; en drops an edge later, never in the same step
  task automatic wr(input int r, input logic [7:0] d);
    ett_pkg::ett_wr_s w;
    w = '{en: 1'b1, data: d};
    cyc(1);
    case (r)
      R_CNT: count_wr = w;
      R_CMPA: compare_a_wr = w;
      R_CMPB: compare_b_wr = w;
      R_CTA: ctrl_a_wr = w;
      R_CTB: ctrl_b_wr = w;
      R_MSK: irq_mask_wr = w;
      default: irq_flag_clr = w;
    endcase
    cyc(1);
    {count_wr, compare_a_wr, compare_b_wr, ctrl_a_wr, ctrl_b_wr,
      irq_mask_wr, irq_flag_clr} = '0;
  endtask
  task automatic wait_flag(input int b); // bounded wait for a flag
    int n;
    n = 0;
    while (timer_irq_flag_reg[b] !== 1'b1 && n < 40)
    begin
      cyc(1);
      n++;
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset;
    check8(count_value | compare_a_value | compare_b_value | control_reg_a
      | control_reg_b | timer_irq_flag_reg | timer_irq_mask_reg, 8'h00);
    check1(count_dir_up, 1'b1);
    $display("reset test done");
  endtask
  task automatic t_regs;
    wr(R_CNT, 8'h5a);
    check8(count_value, 8'h5a);
    wr(R_CMPA, 8'ha5);
    check8(compare_a_value, 8'ha5);
    wr(R_CMPB, 8'h3c);
    check8(compare_b_value, 8'h3c);
    wr(R_CTA, 8'hff);
    check8(control_reg_a, 8'h03);
    wr(R_CTB, 8'hf8);
    check8(control_reg_b, 8'h08);
    wr(R_MSK, 8'hff);
    check8(timer_irq_mask_reg, 8'h07);
    wr(R_CTA, 8'h00);
    wr(R_CTB, 8'h00);
    wr(R_CNT, 8'h10);
    cyc(30);
    check8(count_value, 8'h10);
    wr(R_CNT, 8'h3c);
    cyc(1);
    check1(match_b, 1'b1);
    wr(R_CNT, 8'h00);
    cyc(1);
    check1(at_bottom, 1'b1);
    $display("register test done");
  endtask
  task automatic t_ovf; // normal mode wrap, mask, clear, priority
    wr(R_MSK, 8'h01);
    wr(R_CNT, 8'hfd);
    wr(R_CTB, 8'h01);
    wait_flag(0);
    check8(count_value, 8'h00);
    cyc(2);
    check1(irq_req[0], 1'b1);
    wr(R_CNT, 8'h80);
    check8(count_value, 8'h80);
    cyc(1);
    check8(count_value, 8'h81);
    wr(R_CTB, 8'h00);
    cyc(3);
    wr(6, 8'h01);
    check8(timer_irq_flag_reg, 8'h00);
    cyc(2);
    check1(irq_req[0], 1'b0);
    $display("overflow test done");
  endtask
  task automatic t_match_next; // match flag sets on the tick after the count reaches compare a
    wr(R_CNT, 8'h2f);
    wr(R_CMPA, 8'h30);
    wr(R_CTB, 8'h01);
    wait_flag(1);
    check8(count_value, 8'h31);
    wr(R_CTB, 8'h00);
    $display("match timing test done");
  endtask
  task automatic t_ctc;
    logic [7:0] mx;
    mx = 8'h00;
    wr(6, 8'h07);
    wr(R_CMPA, 8'h05);
    wr(R_CMPB, 8'h03);
    wr(R_CNT, 8'h00);
    wr(R_CTA, 8'h02);
    wr(R_CTB, 8'h01);
    repeat (40)
    begin
      cyc(1);
      if (count_value > mx)
        mx = count_value;
    end
    wr(R_CTB, 8'h00);
    check8(mx, 8'h05);
    check8(timer_irq_flag_reg, 8'h06);
    cyc(1);
    irq_service_ack = 3'b010;
    cyc(1);
    irq_service_ack = 3'h0;
    check8(timer_irq_flag_reg, 8'h04);
    wr(6, 8'h04);
    check8(timer_irq_flag_reg, 8'h00);
    wr(R_CTA, 8'h00);
    $display("clear on match test done");
  endtask
  task automatic t_sources; // prescaler ratios and pin edges
    int divs[5] = '{1, 8, 64, 256, 1024};
    for (int s = 1; s <= 5; s++)
    begin
      wr(R_CNT, 8'h00);
      wr(R_CTB, 8'(s));
      cyc(4 * divs[s - 1]);
      wr(R_CTB, 8'h00);
      check1(count_value inside {[8'h03:8'h05]}, 1'b1);
    end
    for (int s = 7; s >= 6; s--)
    begin
      wr(R_CNT, 8'h00);
      wr(R_CTB, 8'(s));
      repeat (3)
      begin
        cyc(10);
        ext_count_pin = 1'b1;
        cyc(10);
        ext_count_pin = 1'b0;
      end
      cyc(10);
      wr(R_CTB, 8'h00);
      check8(count_value, 8'h03);
    end
    $display("clock source test done");
  endtask
  task automatic t_down; // phase correct turns at max
    logic [7:0] a;
    int n;
    n = 0;
    wr(R_CNT, 8'hfd);
    wr(R_CTA, 8'h01);
    wr(R_CTB, 8'h01);
    while (count_dir_up !== 1'b0 && n < 20)
    begin
      cyc(1);
      n++;
    end
    a = count_value;
    cyc(1);
    check8(count_value, a - 8'h01);
    check1(count_dir_up, 1'b0);
    wr(R_CTB, 8'h00);
    wr(R_CTA, 8'h00);
    $display("down count test done");
  endtask
  task automatic t_fast; // fast pwm restarts at compare a
    logic [7:0] mx;
    mx = 8'h00;
    wr(R_CNT, 8'h00);
    wr(6, 8'h07);
    wr(R_CTA, 8'h03);
    wr(R_CTB, 8'h09);
    repeat (40)
    begin
      cyc(1);
      if (count_value > mx)
        mx = count_value;
    end
    wr(R_CTB, 8'h00);
    check8(mx, 8'h05);
    check1(timer_irq_flag_reg[0], 1'b1);
    wr(R_CTA, 8'h00);
    $display("fast pwm test done");
  endtask
  // ==========================================================
  // clock, sequence and watchdog
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial
  begin
    rst_n = 1'b0;
    ext_count_pin = 1'b0;
    irq_service_ack = 3'h0;
    {count_wr, compare_a_wr, compare_b_wr, ctrl_a_wr, ctrl_b_wr,
      irq_mask_wr, irq_flag_clr} = '0;
    err_total = 0;
    samples_checked = 0;
    repeat (12) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    t_reset;
    t_regs;
    t_ovf;
    t_match_next;
    t_ctc;
    t_sources;
    t_down;
    t_fast;
    finish_test;
  end
  // the full run needs about 5800 cycles
  initial
  begin
    #(20 * 20000);
    err_total++;
    finish_test;
  end
endmodule // tb_ett_timer_core
bind ett_timer_core ett_timer_core_props u_props (
  .core_clk(core_clk), .rst_n(rst_n), .count_wr(count_wr),
  .ctrl_b_wr(ctrl_b_wr), .irq_mask_wr(irq_mask_wr),
  .irq_flag_clr(irq_flag_clr), .irq_service_ack(irq_service_ack),
  .count_value(count_value), .compare_a_value(compare_a_value),
  .control_reg_a(control_reg_a), .control_reg_b(control_reg_b),
  .timer_irq_flag_reg(timer_irq_flag_reg),
  .timer_irq_mask_reg(timer_irq_mask_reg), .irq_req(irq_req),
  .at_max(at_max), .match_a(match_a)
);
